// >>> pin_partner.sv
// Far side of the timer's channel pins: event source and external clock.
// Assumes the timer's pin outputs win whenever their enable is low.
`timescale 1ns/1ps

module pin_partner (
    input wire logic clock_i,
    input wire logic [1:0] pin_o_i,
    input wire logic [1:0] oe_n_i,
    output logic [1:0] level_o
);
    logic [1:0] drive_r = 2'h0;

    // Each pin shows the timer's value while it drives, ours otherwise
    assign level_o[0] = oe_n_i[0] ? drive_r[0] : pin_o_i[0];
    assign level_o[1] = oe_n_i[1] ? drive_r[1] : pin_o_i[1];

    // Eight-cycle period keeps the clock well under a quarter of the bus rate
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clock_i);
            drive_r[0] <= 1'b1;
            repeat (4) @(posedge clock_i);
            drive_r[0] <= 1'b0;
            repeat (3) @(posedge clock_i);
        end
    endtask

    task automatic event_level(input logic v);
        @(posedge clock_i);
        drive_r[1] <= v;
    endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the two-channel timer: reads are checked via a
// queue of expected bytes, pins and irqs directly.
// Assumes the pin partner drives the pins that the timer leaves free.
`timescale 1ns/1ps
`include "timer_pwm_cfg.svh"

module tb_top;
    import timer_pwm_pkg::*;
    localparam reg_addr_t ch1_sc = 4'h8;
    localparam reg_addr_t ch1_hi = 4'h9;
    localparam reg_addr_t ch1_lo = 4'ha;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    reg_addr_t addr_i;
    byte_t wr_data_i;
    logic wr_i;
    logic rd_i;
    byte_t rd_data_o;
    wire logic [1:0] ch_pin_i;
    logic [1:0] ch_pin_o;
    logic [1:0] ch_pin_oe_n_o;
    logic [1:0] ch_irq_o;
    logic overflow_irq_o;
    byte_t exp_q[$];
    int n_errors = 0;
    int checks_done = 0;
    logic rd_seen = 1'b0;
    logic exp_pin = 1'b0;
    int n_high;
    logic [31:0] seed = 32'h0000002c;

    two_channel_timer_pwm #(.CHANNELS(2)) dut_u (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o), .ch_pin_oe_n_o(ch_pin_oe_n_o),
        .ch_irq_o(ch_irq_o), .overflow_irq_o(overflow_irq_o)
    );
    pin_partner partner_u (
        .clock_i(clock_i), .pin_o_i(ch_pin_o), .oe_n_i(ch_pin_oe_n_o),
        .level_o(ch_pin_i)
    );

    initial begin
        forever #10 clock_i = ~clock_i;
    end

    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic wr_reg(input reg_addr_t a, input byte_t d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_exp(input reg_addr_t a, input byte_t e);
        exp_q.push_back(e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clock_i) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                check(1'b0, "read with no expectation");
            end else begin
                check(rd_data_o === exp_q.pop_front(), "read data");
            end
        end
        rd_seen <= rd_i;
    end

    initial begin
        repeat (100000) @(posedge clock_i);
        check(1'b0, "run hung");
        report_and_stop();
    end

    ////////////////////////////////////////
    initial begin
        addr_i <= 4'h0;
        wr_data_i <= 8'h00;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1'b1;
        // Source is off after reset, so the count must still read zero
        idle(300);
        wr_reg(4'hc, 8'hff);
        for (int a = 0; a < 16; a++) begin
            rd_exp(reg_addr_t'(a), `RESET_BYTE);
        end
        $display("reset test done");
        // Divide by 128 keeps the count still for long read sequences
        wr_reg(`ADDR_TIMER_SC, 8'h0f);
        wr_reg(`ADDR_COUNT_LOW, 8'h00);
        idle(10);
        rd_exp(`ADDR_COUNT_LOW, 8'h00);
        idle(290);
        rd_exp(`ADDR_COUNT_LOW, 8'h00);
        rd_exp(`ADDR_COUNT_HIGH, 8'h00);
        rd_exp(`ADDR_COUNT_LOW, 8'h02);
        rd_exp(`ADDR_COUNT_HIGH, 8'h00);
        rd_exp(`ADDR_COUNT_LOW, 8'h02);
        idle(130);
        wr_reg(`ADDR_TIMER_SC, 8'h17);
        rd_exp(`ADDR_COUNT_LOW, 8'h03);
        rd_exp(`ADDR_COUNT_HIGH, 8'h00);
        rd_exp(`ADDR_COUNT_LOW, 8'h03);
        wr_reg(`ADDR_COUNT_HIGH, 8'h5a);
        rd_exp(`ADDR_COUNT_LOW, 8'h00);
        rd_exp(`ADDR_COUNT_HIGH, 8'h00);
        idle(140);
        rd_exp(`ADDR_COUNT_LOW, 8'h01);
        rd_exp(`ADDR_COUNT_HIGH, 8'h00);
        $display("counter test done");
        for (int ps = 1; ps < 8; ps++) begin
            int d;
            d = 1 << ps;
            wr_reg(`ADDR_TIMER_SC, byte_t'(8'h08 | ps));
            wr_reg(`ADDR_COUNT_LOW, 8'h00);
            idle(4 * d + d / 2 - 2);
            rd_exp(`ADDR_COUNT_LOW, 8'h04);
        end
        $display("prescale test done");
        // Pin 0 clocks the counter, so channel 0 must leave it alone
        wr_reg(`ADDR_CH0_SC, 8'h00);
        wr_reg(`ADDR_TIMER_SC, 8'h18);
        for (int e = 1; e < 4; e++) begin
            wr_reg(ch1_sc, byte_t'(8'hc0 | (e << 2)));
            wr_reg(`ADDR_COUNT_LOW, 8'h00);
            partner_u.ext_pulses(2);
            partner_u.event_level(1'b1);
            idle(10);
            check(ch_irq_o[1] === (e != 2), "flag after rise");
            check(ch_pin_oe_n_o === 2'h3 && ch_irq_o[0] === 1'b0, "pins left free");
            partner_u.ext_pulses(3);
            partner_u.event_level(1'b0);
            idle(10);
            check(ch_irq_o[1] === 1'b1, "flag after fall");
            rd_exp(ch1_hi, 8'h00);
            rd_exp(ch1_lo, (e == 1) ? 8'h02 : 8'h05);
        end
        $display("capture test done");
        // Last pass leaves a half pair after the restart: value must stay 3
        for (int e = 1; e < 4; e++) begin
            wr_reg(ch1_lo, 8'h09);
            wr_reg(ch1_sc, byte_t'(8'hd0 | (e << 2)));
            wr_reg(ch1_hi, 8'h00);
            if (e != 3) begin
                wr_reg(ch1_lo, 8'h03);
            end
            wr_reg(`ADDR_COUNT_LOW, 8'h00);
            partner_u.ext_pulses(3);
            idle(6);
            check(ch_irq_o[1] === 1'b0, "early match");
            partner_u.ext_pulses(1);
            idle(6);
            exp_pin = (e == 1) ? ~exp_pin : (e == 3);
            check(ch_irq_o[1] === 1'b1, "match flag");
            check(ch_pin_o[1] === exp_pin && ch_pin_oe_n_o[1] === 1'b0, "pin");
        end
        $display("compare test done");
        wr_reg(`ADDR_TIMER_SC, 8'h48);
        wr_reg(`ADDR_MOD_HIGH, 8'h00);
        wr_reg(`ADDR_MOD_LOW, 8'h09);
        for (int pol = 0; pol < 2; pol++) begin
            int highs;
            byte_t v;
            seed = xs(seed);
            v = byte_t'(seed[2:0]) + 8'h01;
            highs = 0;
            wr_reg(ch1_sc, pol ? 8'h24 : 8'h28);
            wr_reg(ch1_hi, 8'h00);
            wr_reg(ch1_lo, v);
            idle(40);
            // Ten whole periods, so the phase of the window does not matter
            for (int i = 0; i < 100; i++) begin
                @(posedge clock_i);
                highs += (ch_pin_o[1] === 1'b1) ? 1 : 0;
            end
            check(highs == (pol ? 100 - 10 * v : 10 * v), "duty");
        end
        check(overflow_irq_o === 1'b1, "terminal irq");
        wr_reg(`ADDR_TIMER_SC, 8'h28);
        idle(2);
        check(overflow_irq_o === 1'b0, "masked irq");
        // Center mode, modulus 9: 18-step period, count below 4 on seven steps
        wr_reg(ch1_sc, 8'h28);
        wr_reg(ch1_hi, 8'h00);
        wr_reg(ch1_lo, 8'h04);
        idle(60);
        n_high = 0;
        for (int i = 0; i < 180; i++) begin
            @(posedge clock_i);
            n_high += (ch_pin_o[1] === 1'b1) ? 1 : 0;
        end
        check(n_high == 70, "center duty");
        $display("pwm test done");
        idle(4);
        check(exp_q.size() == 0, "reads unanswered");
        report_and_stop();
    end
endmodule

// >>> timer_pwm_cfg.svh
// Register offsets, field positions and reset values of the two-channel timer.
// Assumes a byte-wide register port with a 4-bit register index.
`ifndef TIMER_PWM_CFG_SVH
`define TIMER_PWM_CFG_SVH

`define ADDR_TIMER_SC 4'h0
`define ADDR_COUNT_HIGH 4'h1
`define ADDR_COUNT_LOW 4'h2
`define ADDR_MOD_HIGH 4'h3
`define ADDR_MOD_LOW 4'h4
`define ADDR_CH0_SC 4'h5
`define ADDR_CH0_VAL_HIGH 4'h6
`define ADDR_CH0_VAL_LOW 4'h7
`define ADDR_CH_STRIDE 4'h3
`define ADDR_LAST 4'ha

// Timer status/control fields
`define SC_TOF_BIT 7
`define SC_TOIE_BIT 6
`define SC_CENTER_BIT 5
`define SC_CLKSRC_HI 4
`define SC_CLKSRC_LO 3
`define SC_PS_HI 2
`define SC_PS_LO 0

// Channel status/control fields
`define CH_FLAG_BIT 7
`define CH_IE_BIT 6
`define CH_MS_HI 5
`define CH_MS_LO 4
`define CH_ELS_HI 3
`define CH_ELS_LO 2

`define CLKSRC_NONE 2'h0
`define CLKSRC_EXT 2'h3
`define ELS_OFF 2'h0
`define ELS_RISE_TOGGLE 2'h1
`define ELS_FALL_CLEAR 2'h2
`define ELS_HIGH_TRUE 2'h2
`define MODE_CAPTURE 2'h0
`define MODE_COMPARE 2'h1

`define RESET_BYTE 8'h00
`define RESET_COUNT 16'h0000
`define FULL_RANGE 16'hffff
`define PRESCALE_ONES 7'h7f

`endif

// >>> timer_pwm_pkg.sv
// Types shared by the two-channel timer.
// Assumes the constants header timer_pwm_cfg.svh is included beside it.
package timer_pwm_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] count_t;
    typedef logic [3:0] reg_addr_t;
    typedef enum logic [1:0] {ch_capture, ch_compare, ch_edge_pwm, ch_center_pwm} ch_mode_e;
    typedef enum logic {dir_up, dir_down} count_dir_e;
endpackage

// >>> two_channel_timer_pwm.sv
// Two-channel timer/PWM unit: 16-bit counter, prescaler, modulus, per-channel
// capture, compare and PWM, reached through byte-wide registers.
// Assumes one clock, a byte register port with read data one cycle later,
// and channel pins that arrive asynchronously.
//
// Notes on behaviour
// - 16-bit counter, prescaler and modulus set timing.
// - Source select: off, bus clock, external pin.
// - Fixed system clock code uses bus clock.
// - Prescale divides by one to 128.
// - Counter read latches both bytes until both read.
// - Counter write clears count and read latch.
// - Reset and status/control write restart latch.
// - Reset clears the counter.
// - One bit makes both channels center-aligned.
// - Mode bits pick capture, compare or PWM.
// - Active pin edge captures the counter value.
// - Captured value read coherently, restart on write.
// - Capture sets the channel event flag.
// - Compare match sets, clears or toggles pin.
// - Compare value loads after both bytes written.
// - Compare match sets the channel event flag.
// - Edge PWM: modulus period, channel value duty.
// - PWM polarity selectable per channel.
// - Interrupt per channel plus terminal count.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "timer_pwm_cfg.svh"

module two_channel_timer_pwm #(
    parameter int CHANNELS = 2
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire timer_pwm_pkg::reg_addr_t addr_i,
    input wire timer_pwm_pkg::byte_t wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output timer_pwm_pkg::byte_t rd_data_o,
    input wire logic [CHANNELS-1:0] ch_pin_i,
    output logic [CHANNELS-1:0] ch_pin_o,
    output logic [CHANNELS-1:0] ch_pin_oe_n_o,
    output logic [CHANNELS-1:0] ch_irq_o,
    output logic overflow_irq_o
);
    import timer_pwm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Main status/control and modulus

    logic tof_r;
    logic toie_r;
    logic center_r;
    logic [1:0] clksrc_r;
    logic [2:0] ps_r;
    count_t mod_r;
    count_t cnt_r;
    count_t cnt_nxt;
    count_dir_e dir_r;
    count_dir_e dir_nxt;
    logic [6:0] presc_r;
    count_t cnt_buf_r;
    logic cnt_lat_r;
    logic cnt_first_hi_r;
    byte_t rd_data_r;

    wire wr_sc = wr_i && addr_i == `ADDR_TIMER_SC;
    wire rd_cnt_h = rd_i && addr_i == `ADDR_COUNT_HIGH;
    wire rd_cnt_l = rd_i && addr_i == `ADDR_COUNT_LOW;
    wire wr_cnt = wr_i && (addr_i == `ADDR_COUNT_HIGH || addr_i == `ADDR_COUNT_LOW);
    wire wr_mod_h = wr_i && addr_i == `ADDR_MOD_HIGH;
    wire wr_mod_l = wr_i && addr_i == `ADDR_MOD_LOW;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once stages two and three agree

    logic [CHANNELS-1:0] pin_s1_r;
    logic [CHANNELS-1:0] pin_s2_r;
    logic [CHANNELS-1:0] pin_s3_r;
    logic [CHANNELS-1:0] pin_lvl_r;
    wire [CHANNELS-1:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
    wire [CHANNELS-1:0] pin_lvl_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_lvl_r);
    wire [CHANNELS-1:0] pin_rise = pin_lvl_nxt & ~pin_lvl_r;
    wire [CHANNELS-1:0] pin_fall = ~pin_lvl_nxt & pin_lvl_r;

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            pin_lvl_r <= '0;
        end else begin
            pin_s1_r <= ch_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock source and prescaler

    // Any code but off and external runs from the bus clock; no fixed clock here
    wire src_pulse = (clksrc_r == `CLKSRC_EXT) ? pin_rise[0] :
                     (clksrc_r != `CLKSRC_NONE);
    wire [6:0] presc_mask = ~(`PRESCALE_ONES << ps_r);
    wire tick = src_pulse && ((presc_r & presc_mask) == presc_mask);
    wire [6:0] presc_nxt = presc_r + 7'h01;
    wire count_t top = (mod_r == `RESET_COUNT) ? `FULL_RANGE : mod_r;
    wire at_top = cnt_r >= top;
    wire at_bottom = cnt_r == `RESET_COUNT;

    // Counter sequencing, one step per prescaled tick
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (tick) begin
            if (!center_r) begin
                cnt_nxt = at_top ? `RESET_COUNT : cnt_r + 16'h0001;
                dir_nxt = dir_up;
            end else begin
                unique case (dir_r)
                    dir_up: begin
                        cnt_nxt = at_top ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
                        dir_nxt = at_top ? dir_down : dir_up;
                    end
                    dir_down: begin
                        cnt_nxt = at_bottom ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
                        dir_nxt = at_bottom ? dir_up : dir_down;
                    end
                endcase
            end
        end
    end

    wire period_end = tick && (center_r ? (dir_r == dir_down && at_bottom) : at_top);

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            cnt_r <= `RESET_COUNT;
            dir_r <= dir_up;
            presc_r <= '0;
        end else if (wr_cnt) begin
            cnt_r <= `RESET_COUNT;
            dir_r <= dir_up;
            presc_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
            presc_r <= src_pulse ? presc_nxt : presc_r;
        end
    end

    // Write one to the terminal-count flag clears it; a new overflow wins
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            tof_r <= 1'b0;
            toie_r <= 1'b0;
            center_r <= 1'b0;
            clksrc_r <= `CLKSRC_NONE;
            ps_r <= '0;
            mod_r <= `RESET_COUNT;
        end else begin
            tof_r <= period_end || (tof_r && !(wr_sc && wr_data_i[`SC_TOF_BIT]));
            if (wr_sc) begin
                toie_r <= wr_data_i[`SC_TOIE_BIT];
                center_r <= wr_data_i[`SC_CENTER_BIT];
                clksrc_r <= wr_data_i[`SC_CLKSRC_HI:`SC_CLKSRC_LO];
                ps_r <= wr_data_i[`SC_PS_HI:`SC_PS_LO];
            end
            if (wr_mod_h) begin
                mod_r[15:8] <= wr_data_i;
            end
            if (wr_mod_l) begin
                mod_r[7:0] <= wr_data_i;
            end
        end
    end

    // Counter read latch: the first byte read freezes both, the other releases
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || wr_cnt || wr_sc) begin
            cnt_lat_r <= 1'b0;
            cnt_buf_r <= `RESET_COUNT;
            cnt_first_hi_r <= 1'b0;
        end else if ((rd_cnt_h || rd_cnt_l) && !cnt_lat_r) begin
            cnt_lat_r <= 1'b1;
            cnt_buf_r <= cnt_r;
            cnt_first_hi_r <= rd_cnt_h;
        end else if ((rd_cnt_h && !cnt_first_hi_r) || (rd_cnt_l && cnt_first_hi_r)) begin
            cnt_lat_r <= 1'b0;
        end
    end

    wire count_t cnt_view = cnt_lat_r ? cnt_buf_r : cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Channels

    byte_t ch_sc_view [CHANNELS];
    count_t ch_val_view [CHANNELS];
    count_t ch_val_r [CHANNELS];
    logic [CHANNELS-1:0] ch_flag_r;
    logic [CHANNELS-1:0] ch_ie_r;
    logic [CHANNELS-1:0] cap_ev;
    logic [CHANNELS-1:0] cmp_ev;
    ch_mode_e ch_mode [CHANNELS];

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_ch
            localparam reg_addr_t BASE = 4'(`ADDR_CH0_SC + g * `ADDR_CH_STRIDE);
            logic [1:0] ms_r;
            logic [1:0] els_r;
            count_t wbuf_r;
            logic [1:0] wseq_r;
            logic pend_r;
            count_t rbuf_r;
            logic rlat_r;
            logic rfirst_hi_r;
            logic out_r;

            wire wr_csc = wr_i && addr_i == BASE;
            wire wr_vh = wr_i && addr_i == BASE + 4'h1;
            wire wr_vl = wr_i && addr_i == BASE + 4'h2;
            wire rd_vh = rd_i && addr_i == BASE + 4'h1;
            wire rd_vl = rd_i && addr_i == BASE + 4'h2;
            wire [1:0] wseq_nxt = wseq_r | {wr_vh, wr_vl};
            wire count_t wnew = {wr_vh ? wr_data_i : wbuf_r[15:8],
                                 wr_vl ? wr_data_i : wbuf_r[7:0]};
            wire both_written = (wr_vh || wr_vl) && wseq_nxt == 2'h3;
            wire is_pwm = ch_mode[g] == ch_edge_pwm || ch_mode[g] == ch_center_pwm;
            wire match = tick && cnt_r == ch_val_r[g];
            // High-true when the select is 2, otherwise low-true
            wire pwm_level = (cnt_r < ch_val_r[g]) ^ (els_r != `ELS_HIGH_TRUE);

            assign ch_mode[g] = center_r ? ch_center_pwm :
                                (ms_r == `MODE_CAPTURE) ? ch_capture :
                                (ms_r == `MODE_COMPARE) ? ch_compare : ch_edge_pwm;
            assign cap_ev[g] = ch_mode[g] == ch_capture &&
                               ((els_r[0] && pin_rise[g]) || (els_r[1] && pin_fall[g]));
            assign cmp_ev[g] = ch_mode[g] == ch_compare && match;

            always_ff @(posedge clock_i) begin
                if (!reset_n_i) begin
                    ms_r <= '0;
                    els_r <= `ELS_OFF;
                    ch_ie_r[g] <= 1'b0;
                    ch_flag_r[g] <= 1'b0;
                end else begin
                    // Flag clear by writing one; an event in the same cycle wins
                    ch_flag_r[g] <= cap_ev[g] || cmp_ev[g] ||
                        (ch_flag_r[g] && !(wr_csc && wr_data_i[`CH_FLAG_BIT]));
                    if (wr_csc) begin
                        ch_ie_r[g] <= wr_data_i[`CH_IE_BIT];
                        ms_r <= wr_data_i[`CH_MS_HI:`CH_MS_LO];
                        els_r <= wr_data_i[`CH_ELS_HI:`CH_ELS_LO];
                    end
                end
            end

            // Paired writes; PWM values wait for the period end so no glitch pulse
            always_ff @(posedge clock_i) begin
                if (!reset_n_i) begin
                    ch_val_r[g] <= `RESET_COUNT;
                    wbuf_r <= `RESET_COUNT;
                    wseq_r <= '0;
                    pend_r <= 1'b0;
                end else begin
                    wbuf_r <= wnew;
                    wseq_r <= (wr_csc || both_written) ? 2'h0 : wseq_nxt;
                    if (cap_ev[g]) begin
                        ch_val_r[g] <= cnt_r;
                    end else if (both_written && !is_pwm) begin
                        ch_val_r[g] <= wnew;
                    end else if (pend_r && period_end) begin
                        ch_val_r[g] <= wbuf_r;
                    end
                    pend_r <= (both_written && is_pwm) || (pend_r && !period_end);
                end
            end

            always_ff @(posedge clock_i) begin
                if (!reset_n_i || wr_csc) begin
                    rlat_r <= 1'b0;
                    rbuf_r <= `RESET_COUNT;
                    rfirst_hi_r <= 1'b0;
                end else if ((rd_vh || rd_vl) && !rlat_r) begin
                    rlat_r <= 1'b1;
                    rbuf_r <= ch_val_r[g];
                    rfirst_hi_r <= rd_vh;
                end else if ((rd_vh && !rfirst_hi_r) || (rd_vl && rfirst_hi_r)) begin
                    rlat_r <= 1'b0;
                end
            end

            always_ff @(posedge clock_i) begin
                if (!reset_n_i) begin
                    out_r <= 1'b0;
                end else if (is_pwm && els_r != `ELS_OFF) begin
                    out_r <= pwm_level;
                end else if (cmp_ev[g]) begin
                    unique case (els_r)
                        `ELS_RISE_TOGGLE: out_r <= !out_r;
                        `ELS_FALL_CLEAR: out_r <= 1'b0;
                        `ELS_OFF: out_r <= out_r;
                        default: out_r <= 1'b1;
                    endcase
                end
            end

            assign ch_val_view[g] = rlat_r ? rbuf_r : ch_val_r[g];
            assign ch_sc_view[g] = {ch_flag_r[g], ch_ie_r[g], ms_r, els_r, 2'h0};
            assign ch_pin_o[g] = out_r;
            // Capture inputs and a released pin are left undriven
            assign ch_pin_oe_n_o[g] = ch_mode[g] == ch_capture || els_r == `ELS_OFF;
            assign ch_irq_o[g] = ch_flag_r[g] && ch_ie_r[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register read port

    byte_t rmap [16];
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            rmap[i] = `RESET_BYTE;
        end
        rmap[`ADDR_TIMER_SC] = {tof_r, toie_r, center_r, clksrc_r, ps_r};
        rmap[`ADDR_COUNT_HIGH] = cnt_view[15:8];
        rmap[`ADDR_COUNT_LOW] = cnt_view[7:0];
        rmap[`ADDR_MOD_HIGH] = mod_r[15:8];
        rmap[`ADDR_MOD_LOW] = mod_r[7:0];
        for (int c = 0; c < CHANNELS; c++) begin
            rmap[`ADDR_CH0_SC + c * `ADDR_CH_STRIDE] = ch_sc_view[c];
            rmap[`ADDR_CH0_VAL_HIGH + c * `ADDR_CH_STRIDE] = ch_val_view[c][15:8];
            rmap[`ADDR_CH0_VAL_LOW + c * `ADDR_CH_STRIDE] = ch_val_view[c][7:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            rd_data_r <= `RESET_BYTE;
        end else begin
            rd_data_r <= rd_i ? rmap[addr_i] : `RESET_BYTE;
        end
    end

    assign rd_data_o = rd_data_r;
    assign overflow_irq_o = tof_r && toie_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_cnt_first_read;
        (rd_cnt_h || rd_cnt_l) && !cnt_lat_r && !wr_sc && !wr_cnt;
    endsequence

    sequence s_ch1_capture;
        cap_ev[1] && !(wr_i && addr_i == `ADDR_CH0_SC + `ADDR_CH_STRIDE);
    endsequence

    property p_stopped_holds;
        clksrc_r == `CLKSRC_NONE && !wr_cnt |=> cnt_r == $past(cnt_r);
    endproperty
    a_stopped_holds: assert property (p_stopped_holds) else $error("count moved while stopped");

    property p_bus_step;
        clksrc_r != `CLKSRC_NONE && clksrc_r != `CLKSRC_EXT && ps_r == 3'h0 && !center_r
            && !at_top && !wr_cnt |=> cnt_r == $past(cnt_r) + 16'h0001;
    endproperty
    a_bus_step: assert property (p_bus_step) else $error("bus clock did not step counter");

    property p_div2_spacing;
        tick && ps_r == 3'h1 && !wr_cnt && !wr_sc |=> !tick;
    endproperty
    a_div2_spacing: assert property (p_div2_spacing) else $error("prescale two ticked twice");

    property p_wrap;
        tick && !center_r && at_top && !wr_cnt |=> cnt_r == `RESET_COUNT && tof_r;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap at modulus");

    property p_cnt_write;
        wr_cnt |=> cnt_r == `RESET_COUNT && !cnt_lat_r;
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("count write did not clear");

    property p_sc_restart;
        wr_sc |=> !cnt_lat_r;
    endproperty
    a_sc_restart: assert property (p_sc_restart) else $error("control write kept latch");

    property p_read_freeze;
        s_cnt_first_read |=> cnt_lat_r && cnt_buf_r == $past(cnt_r);
    endproperty
    a_read_freeze: assert property (p_read_freeze) else $error("first count read not latched");

    property p_capture;
        s_ch1_capture |=> ch_val_r[1] == $past(cnt_r) && ch_flag_r[1];
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost count or flag");

    property p_compare_flag;
        cmp_ev[1] |=> ch_flag_r[1] ##0 ch_irq_o[1] == ch_ie_r[1];
    endproperty
    a_compare_flag: assert property (p_compare_flag) else $error("compare did not flag");

    property p_center_turn;
        tick && center_r && dir_r == dir_up && at_top && !wr_cnt |=> dir_r == dir_down;
    endproperty
    a_center_turn: assert property (p_center_turn) else $error("center count did not turn");
endmodule
